//--- rtl/interrupt_priority_resolver.sv
// interrupt priority resolver: picks one pending source and its level each clock
// assumes all inputs are synchronous to clk; the core sequencer samples winner
`timescale 1ns/1ps

module interrupt_priority_resolver
  import irq_resolver_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // level 3 requests, index order per level 3 ranking
  input wire logic [NUM_LEVEL3-1:0] level3_request,
  // external pins, active low, bit 0 is pin a
  input wire logic ext_request_a_n,
  input wire logic ext_request_b_n,
  input wire logic ext_request_c_n,
  input wire logic ext_request_d_n,
  input wire logic [3:0] pin_trigger_mode_bit,
  input wire logic [3:0] ext_edge_clear,
  // maskable peripheral requests and their levels
  input wire logic [5:0] dma_request,
  input wire logic [2:0] host_request,
  input wire logic [5:0] sync_serial_port0,
  input wire logic [5:0] sync_serial_port1,
  input wire logic [4:0] async_serial_port,
  input wire logic [5:0] timer_request,
  input wire logic [2*NUM_SOURCES-1:0] priority_level,
  input wire logic [3:0] ext_enable,
  // status register mask
  input wire logic [1:0] status_mask,
  // to the core sequencer
  output winner_t winner
);

  ////////////////////////////////////////////////////////////////////////////
  // external pin capture

  logic [3:0] pins_n;
  logic [3:0] pins_prev;
  logic [3:0] pin_fell;
  logic [3:0] edge_latch;
  logic [3:0] next_pins_prev;
  logic [3:0] next_edge_latch;
  logic [3:0] ext_pending;

  assign pins_n = {ext_request_d_n, ext_request_c_n, ext_request_b_n, ext_request_a_n};
  assign pin_fell = pins_prev & ~pins_n;

  always_comb begin
    next_pins_prev = pins_n;
    // set wins over clear so an edge in the clearing cycle is kept
    // a level-mode pin keeps no latch, so switching a pin to edge mode cannot serve a stale edge
    next_edge_latch = ((edge_latch & ~ext_edge_clear) | pin_fell) & pin_trigger_mode_bit;
  end

  // per pin, the mode bit picks the latched falling edge or the live low level
  for (genvar p = 0; p < 4; p++) begin : g_pin
    assign ext_pending[p] = pin_trigger_mode_bit[p] ? edge_latch[p] : ~pins_n[p];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_prev <= PIN_IDLE_RESET;
      edge_latch <= EDGE_LATCH_RESET;
    end else begin
      pins_prev <= next_pins_prev;
      edge_latch <= next_edge_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending vector in ranking order; index 0 ranks highest

  // index map: 0-5 level 3, 6-9 pins a-d, 10-15 dma, 16-18 host,
  // 19-24 serial port 0, 25-30 serial port 1, 31-35 async port, 36-41 timers
  logic [NUM_SOURCES-1:0] pending;
  logic [1:0] src_level [NUM_SOURCES];

  always_comb begin
    pending = '0;
    pending[SRC_NONMASK:SRC_HW_RESET] = level3_request;
    pending[SRC_EXT_A +: 4] = ext_pending & ext_enable;
    pending[SRC_DMA0 +: 6] = dma_request;
    // host input bits: 0 command, 1 transmit empty, 2 receive full
    pending[SRC_HOST_CMD] = host_request[0];
    pending[SRC_HOST_TX_EMPTY] = host_request[1];
    pending[SRC_HOST_RX_FULL] = host_request[2];
    // serial bits 0..5 already in rank order: rx exc, rx, rx last, tx exc, tx last, tx
    pending[SRC_SSP0_BASE +: 6] = sync_serial_port0;
    pending[SRC_SSP1_BASE +: 6] = sync_serial_port1;
    // async bits: rx exc, rx, tx, idle, timer
    pending[SRC_ASP_BASE +: 5] = async_serial_port;
    // timer bits: t0 ovf, t0 cmp, t1 ovf, t1 cmp, t2 ovf, t2 cmp
    pending[SRC_TIMER_BASE +: 6] = timer_request;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (i < NUM_LEVEL3) begin
        src_level[i] = LEVEL_TOP;
      end else begin
        // a maskable source programmed to level 3 is treated as level 2
        src_level[i] = (priority_level[2*i +: 2] == LEVEL_TOP) ? 2'h2 : priority_level[2*i +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask: level 3 always passes; a maskable source needs a level at or above the mask

  logic [NUM_SOURCES-1:0] eligible;

  always_comb begin
    eligible = '0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      eligible[i] = pending[i] && (i < NUM_LEVEL3 || src_level[i] >= status_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resolve: first eligible source on each level, then the highest level that has one

  logic [3:0] level_found;
  logic [SRC_W-1:0] level_first [4];
  winner_t next_winner;

  // scanning downward from the top index leaves the lowest index, the highest rank, written last
  always_comb begin
    level_found = '0;
    for (int lv = 0; lv < 4; lv++) begin
      level_first[lv] = '0;
      for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
        if (eligible[i] && src_level[i] == lv[1:0]) begin
          level_found[lv] = 1'b1;
          level_first[lv] = i[SRC_W-1:0];
        end
      end
    end
  end

  // levels are visited upward, so the highest level holding a candidate is written last
  always_comb begin
    next_winner = '0;
    for (int lv = 0; lv < 4; lv++) begin
      if (level_found[lv]) begin
        next_winner.valid = 1'b1;
        next_winner.source = level_first[lv];
        next_winner.level = lv[1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      winner <= '0;
    end else begin
      winner <= next_winner;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks: the source map must tile the pending vector in rank order

  if (SRC_HW_RESET != 0 || SRC_NONMASK + 1 != NUM_LEVEL3) begin : g_bad_level3
    $error("level 3 sources must fill the lowest indices");
  end

  if (SRC_EXT_A != NUM_LEVEL3) begin : g_bad_pins
    $error("external pins must follow the level 3 block");
  end

  if (SRC_DMA0 != SRC_EXT_A + 4) begin : g_bad_dma
    $error("dma channels must follow the four pins");
  end

  if (SRC_HOST_CMD != SRC_DMA0 + 6) begin : g_bad_host
    $error("host sources must follow the six dma channels");
  end

  if (SRC_HOST_TX_EMPTY != SRC_HOST_CMD + 1 || SRC_HOST_RX_FULL != SRC_HOST_CMD + 2) begin : g_bad_host_order
    $error("host sources must rank command, transmit empty, receive full");
  end

  if (SRC_SSP0_BASE != SRC_HOST_CMD + 3) begin : g_bad_port0
    $error("serial port 0 must follow the host sources");
  end

  if (SRC_SSP1_BASE != SRC_SSP0_BASE + 6) begin : g_bad_port1
    $error("serial port 1 must follow serial port 0");
  end

  if (SRC_ASP_BASE != SRC_SSP1_BASE + 6) begin : g_bad_async
    $error("async port must follow serial port 1");
  end

  if (SRC_TIMER_BASE != SRC_ASP_BASE + 5) begin : g_bad_timer
    $error("timers must follow the async port");
  end

  if (NUM_SOURCES != SRC_TIMER_BASE + 6) begin : g_bad_count
    $error("source count must end with the last timer");
  end

  if (NUM_SOURCES > (1 << SRC_W)) begin : g_bad_width
    $error("source index width too narrow for the source count");
  end

  if (LEVEL_TOP != 2'h3) begin : g_bad_top
    $error("the level clamp assumes level 3 is the top two-bit level");
  end

  if (PIN_IDLE_RESET != 4'hF || EDGE_LATCH_RESET != 4'h0) begin : g_bad_pin_reset
    $error("pin history must reset idle high with no edge latched");
  end

endmodule

//--- rtl/irq_resolver_pkg.sv
// package for the interrupt priority resolver: source indices, levels, carriers
// assumes the core clock drives everything; no software-reachable registers
package irq_resolver_pkg;

  localparam int NUM_SOURCES = 42;
  localparam int SRC_W = 6;
  localparam int NUM_LEVEL3 = 6;

  // level 3 order, highest first
  localparam logic [5:0] SRC_HW_RESET = 6'h00;
  localparam logic [5:0] SRC_STACK_ERR = 6'h01;
  localparam logic [5:0] SRC_ILLEGAL = 6'h02;
  localparam logic [5:0] SRC_DEBUG = 6'h03;
  localparam logic [5:0] SRC_TRAP = 6'h04;
  localparam logic [5:0] SRC_NONMASK = 6'h05;
  // maskable order, highest first
  localparam logic [5:0] SRC_EXT_A = 6'h06;
  localparam logic [5:0] SRC_DMA0 = 6'h0A;
  localparam logic [5:0] SRC_HOST_CMD = 6'h10;
  localparam logic [5:0] SRC_HOST_TX_EMPTY = 6'h11;
  localparam logic [5:0] SRC_HOST_RX_FULL = 6'h12;
  localparam logic [5:0] SRC_SSP0_BASE = 6'h13;
  localparam logic [5:0] SRC_SSP1_BASE = 6'h19;
  localparam logic [5:0] SRC_ASP_BASE = 6'h1F;
  localparam logic [5:0] SRC_TIMER_BASE = 6'h24;

  localparam logic [1:0] LEVEL_TOP = 2'h3;
  localparam logic [3:0] EXT_MODE_RESET = 4'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [3:0] PIN_IDLE_RESET = 4'hF;
  localparam logic [3:0] EDGE_LATCH_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic [SRC_W-1:0] source;
    logic [1:0] level;
  } winner_t;

endpackage

//--- test/core_sequencer_model.sv
// core sequencer stand-in: takes the winner and acknowledges pin sources
// assumes winner is registered on clk
`timescale 1ns/1ps
module core_sequencer_model
  import irq_resolver_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input winner_t winner,
  output logic [3:0] ack
);
  // an edge-latched pin stays pending until it is taken, so acknowledge on service
  always @(posedge clk or posedge reset) begin
    if (reset)
      ack <= 4'h0;
    else
      ack <= (winner.valid && winner.source >= SRC_EXT_A && winner.source < SRC_DMA0) ?
        4'(4'h1 << (winner.source - SRC_EXT_A)) : 4'h0;
  end
endmodule

//--- test/irq_resolver_checker.sv
// checker for the resolver, sees its ports only
// assumes one clock domain and the active-high async reset
`timescale 1ns/1ps
module irq_resolver_checker
  import irq_resolver_pkg::*;
(
  input wire logic clk, reset, ext_request_a_n, ext_request_b_n, ext_request_c_n, ext_request_d_n,
  input wire logic [NUM_LEVEL3-1:0] level3_request,
  input wire logic [3:0] pin_trigger_mode_bit, ext_edge_clear, ext_enable,
  input wire logic [5:0] dma_request, sync_serial_port0, sync_serial_port1, timer_request,
  input wire logic [2:0] host_request,
  input wire logic [4:0] async_serial_port,
  input wire logic [2*NUM_SOURCES-1:0] priority_level,
  input wire logic [1:0] status_mask,
  input winner_t winner
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // disabled pins cannot pend, so pin levels are left out
  wire logic none = ~|{level3_request, dma_request, host_request, sync_serial_port0,
    sync_serial_port1, async_serial_port, timer_request, ext_enable};
  sequence s_fall;
    $fell(ext_request_a_n) && pin_trigger_mode_bit[0] && ext_enable[0];
  endsequence
  sequence s_kept;
    status_mask == 2'h0 && ext_enable[0] && pin_trigger_mode_bit[0];
  endsequence
  a_level3_wins: assert property (|level3_request |=> winner.valid && winner.level == 2'h3)
    else $error("level 3 request did not win");
  a_hw_reset_first: assert property (level3_request[0] |=> winner.source == SRC_HW_RESET)
    else $error("hardware reset source lost");
  a_level3_ids: assert property (winner.valid && winner.level == 2'h3 |-> winner.source < 6'h06)
    else $error("level 3 given to a maskable source");
  a_mask_top: assert property (status_mask == 2'h3 && !(|level3_request) |=> !winner.valid)
    else $error("masked request was presented");
  a_mask_floor: assert property (winner.valid && winner.source >= 6'h06 |->
    winner.level != LEVEL_TOP && winner.level >= $past(status_mask))
    else $error("maskable winner below mask");
  a_no_request: assert property (none |=> !winner.valid)
    else $error("winner valid with nothing pending");
  a_dma_pending: assert property (dma_request[0] && status_mask == 2'h0 |=> winner.valid)
    else $error("pending dma request not presented");
  a_edge_latency: assert property (s_fall ##1 s_kept |=> winner.valid)
    else $error("falling edge on pin a not presented");
endmodule
bind interrupt_priority_resolver irq_resolver_checker u_chk (.*);

//--- test/tb_interrupt_priority_resolver.sv
// testbench for the resolver: directed corners, then seeded random requests
// assumes inputs change at the falling edge and winner lags one clock
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_interrupt_priority_resolver;
  import irq_resolver_pkg::*;
  logic clk = 0, reset = 1, ext_request_a_n = 1, ext_request_b_n = 1, ext_request_c_n = 1, ext_request_d_n = 1;
  logic [5:0] level3_request = '0, dma_request = '0, sync_serial_port0 = '0, sync_serial_port1 = '0, timer_request = '0;
  logic [3:0] pin_trigger_mode_bit = '0, ext_enable = '0, ext_edge_clear;
  logic [2:0] host_request = '0;
  logic [4:0] async_serial_port = '0;
  logic [1:0] status_mask = '0;
  localparam int PL_W = 2 * NUM_SOURCES;
  logic [PL_W-1:0] priority_level = '0;
  winner_t winner;
  int err_total = 0, n_compared = 0, cyc = 0;
  interrupt_priority_resolver DUT (.*);
  core_sequencer_model seq (.clk(clk), .reset(reset), .winner(winner), .ack(ext_edge_clear));
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin err_total++; summarize(); end
  task summarize;
    $display("errors %0d compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // highest level wins; scanning downward from the top index lets the lower index take ties
  function automatic winner_t expect_w();
    logic [NUM_SOURCES-1:0] p;
    winner_t w;
    logic [1:0] l;
    p = {timer_request, async_serial_port, sync_serial_port1, sync_serial_port0, host_request, dma_request,
      ext_enable & ~{ext_request_d_n, ext_request_c_n, ext_request_b_n, ext_request_a_n}, level3_request};
    w = '0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      l = (i < 6) ? 2'h3 : priority_level[2*i+:2];
      if (i >= 6 && l == 2'h3) l = 2'h2;
      if (p[i] && l >= status_mask && (!w.valid || l >= w.level)) w = '{1'b1, 6'(i), l};
    end
    return w;
  endfunction
  task tick;
    @(negedge clk);
    `CHK("winner", expect_w(), winner)
  endtask
  initial begin
    void'($urandom(64));
    repeat (8) @(negedge clk);
    reset = 0;
    level3_request = 6'h3F;
    tick();
    level3_request = 6'h20; dma_request = 6'h3F;
    tick();
    level3_request = '0; dma_request = '0; ext_enable = 4'hF; priority_level = {NUM_SOURCES{2'h1}};
    sync_serial_port1 = 6'h01; sync_serial_port0 = 6'h20;
    tick();
    status_mask = 2'h3; priority_level = {NUM_SOURCES{2'h3}};
    tick();
    status_mask = '0; sync_serial_port0 = '0; sync_serial_port1 = '0; pin_trigger_mode_bit = 4'h1; ext_request_a_n = 0;
    @(negedge clk);
    `CHK("edge early", 1'b0, winner.valid)
    @(negedge clk);
    `CHK("edge source", SRC_EXT_A, winner.source)
    `CHK("edge level", 2'h2, winner.level)
    ext_request_a_n = 1;
    repeat (4) @(negedge clk);
    `CHK("edge cleared", 1'b0, winner.valid)
    pin_trigger_mode_bit = '0; ext_enable = '0;
    tick();
    for (int i = 0; i < 400; i++) begin
      level3_request = ($urandom % 8 == 0) ? 6'($urandom) : '0;
      {ext_request_d_n, ext_request_c_n, ext_request_b_n, ext_request_a_n} = 4'($urandom);
      ext_enable = 4'($urandom);
      {timer_request, async_serial_port, sync_serial_port1, sync_serial_port0, host_request, dma_request} =
        36'({$urandom, $urandom} & {$urandom, $urandom});
      status_mask = 2'($urandom);
      priority_level = i[0] ? PL_W'({$urandom, $urandom, $urandom}) : {NUM_SOURCES{2'(i >> 1)}};
      tick();
    end
    level3_request = 6'h3F;
    reset = 1;
    @(negedge clk);
    `CHK("reset winner", 1'b0, winner.valid)
    reset = 0;
    tick();
    summarize();
  end
endmodule
